// file: src/fdi_params.svh
`ifndef FDI_PARAMS_SVH
`define FDI_PARAMS_SVH

// register offsets
`define FDI_REG_CTRL 4'h0
`define FDI_REG_TRACK 4'h1
`define FDI_REG_WDATA 4'h2
`define FDI_REG_STATUS 4'h3
`define FDI_REG_STEPCFG 4'h4

// control register fields
`define FDI_CTRL_SEL0 0
`define FDI_CTRL_SEL1 1
`define FDI_CTRL_SEL23 2
`define FDI_CTRL_HEAD1 3
`define FDI_CTRL_HLOAD 4
`define FDI_CTRL_WREQ 5
`define FDI_CTRL_OPT 6
`define FDI_CTRL_RESET 8'h00

// command bits in the track register write
`define FDI_STEP_GO 0
`define FDI_STEP_DIR 1

// status register fields
`define FDI_ST_TRK0 0
`define FDI_ST_RDY0 1
`define FDI_ST_RDY1 2
`define FDI_ST_WPERM 3
`define FDI_ST_INDEX 4
`define FDI_ST_RAW 5
`define FDI_ST_BUSY 6
`define FDI_ST_WGATE 7

// timing, in ns, and derived cycles at 50 ns
`define FDI_CLK_NS 50
`define FDI_STEP_PULSE_NS 1000
`define FDI_STEP_PULSE_CYC ((`FDI_STEP_PULSE_NS + `FDI_CLK_NS - 1) / `FDI_CLK_NS)
`define FDI_DIR_SETUP_NS 1000
`define FDI_DIR_SETUP_CYC ((`FDI_DIR_SETUP_NS + `FDI_CLK_NS - 1) / `FDI_CLK_NS)
`define FDI_WPULSE_NS 250
`define FDI_WPULSE_CYC ((`FDI_WPULSE_NS + `FDI_CLK_NS - 1) / `FDI_CLK_NS)
`define FDI_STEP_GAP_RESET 16'h0c80

// track boundary for write current and last track for seeking
`define FDI_LAST_OUTER_TRACK 7'h2b
`define FDI_LAST_TRACK 7'h4c

`endif

// file: src/fdi_pkg.sv
package fdi_pkg;

  typedef struct packed {
    logic trk0_n;
    logic ready0_n;
    logic ready1_n;
    logic wperm_n;
    logic index_n;
    logic raw_data;
  } fdi_drive_in_type;

  typedef struct packed {
    logic sel0_n;
    logic sel1_n;
    logic sel23;
    logic head1;
    logic hload_n;
    logic seek_in;
    logic step_n;
    logic wgate_n;
    logic wpulse_n;
    logic above43_n;
  } fdi_drive_out_type;

  typedef enum logic [3:0] {
    FDI_SEEK_IDLE = 4'b0001,
    FDI_SEEK_SETUP = 4'b0010,
    FDI_SEEK_PULSE = 4'b0100,
    FDI_SEEK_GAP = 4'b1000
  } fdi_seek_state_type;

endpackage : fdi_pkg

// file: src/fdi_write_pulser.sv
`timescale 1ns/1ns
`include "fdi_params.svh"

// ****************************************
// write pulse shaper
// ****************************************
module fdi_write_pulser
  import fdi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic gate,
  input wire logic flux,
  // pin
  output logic wpulse_n
);

  localparam int unsigned WIDTH = `FDI_WPULSE_CYC;

  logic [3:0] count;
  logic [3:0] next_count;
  logic pulse_n;
  logic next_pulse_n;

  always_comb
  begin
    next_count = count;
    next_pulse_n = 1'b1;
    if (count != 4'h0)
    begin
      next_count = count - 4'h1;
      next_pulse_n = 1'b0;
    end
    else if (gate && flux && pulse_n)
    begin
      // leading edge reverses write current
      next_count = 4'(WIDTH - 1);
      next_pulse_n = 1'b0;
    end
    if (!gate)
    begin
      next_count = 4'h0;
      next_pulse_n = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= 4'h0;
      pulse_n <= 1'b1;
    end
    else
    begin
      count <= next_count;
      pulse_n <= next_pulse_n;
    end
  end

  assign wpulse_n = pulse_n;

endmodule : fdi_write_pulser

// file: src/fdi_drive_if.sv
`timescale 1ns/1ns
`include "fdi_params.svh"


// ****************************************
// drive side signal interface
// ****************************************
module fdi_drive_if
  import fdi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // drive pins
  input wire fdi_drive_in_type drv_in,
  output fdi_drive_out_type drv_out
);

  // ****************************************
  // input synchronisers
  // ****************************************
  fdi_drive_in_type sync_a;
  fdi_drive_in_type sync_b;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= '1;
      sync_b <= '1;
    end
    else
    begin
      sync_a <= drv_in;
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [6:0] track;
  logic [6:0] next_track;
  logic [15:0] step_gap;
  logic [15:0] next_step_gap;
  logic flux;
  logic [7:0] next_rdata;
  logic [7:0] status;
  logic wgate;
  logic busy;
  logic step_req;
  logic step_dir_in;

  assign step_req = wr && (addr == `FDI_REG_TRACK) && wdata[`FDI_STEP_GO];
  assign step_dir_in = wdata[`FDI_STEP_DIR];
  assign flux = wr && (addr == `FDI_REG_WDATA) && wdata[0];

  assign wgate = ctrl[`FDI_CTRL_WREQ] && !sync_b.wperm_n
    && ((ctrl[`FDI_CTRL_SEL0] && !sync_b.ready0_n)
    || (ctrl[`FDI_CTRL_SEL1] && !sync_b.ready1_n));

  always_comb
  begin
    status = 8'h00;
    status[`FDI_ST_TRK0] = !sync_b.trk0_n;
    status[`FDI_ST_RDY0] = !sync_b.ready0_n;
    status[`FDI_ST_RDY1] = !sync_b.ready1_n;
    status[`FDI_ST_WPERM] = !sync_b.wperm_n;
    status[`FDI_ST_INDEX] = !sync_b.index_n;
    status[`FDI_ST_RAW] = sync_b.raw_data;
    status[`FDI_ST_BUSY] = busy;
    status[`FDI_ST_WGATE] = wgate;
  end

  always_comb
  begin
    next_ctrl = ctrl;
    next_step_gap = step_gap;
    next_rdata = 8'h00;
    if (wr && addr == `FDI_REG_CTRL)
    begin
      next_ctrl = wdata;
      // two drive selects never both active
      if (wdata[`FDI_CTRL_SEL0])
      begin
        next_ctrl[`FDI_CTRL_SEL1] = 1'b0;
      end
    end
    if (wr && addr == `FDI_REG_STEPCFG)
    begin
      next_step_gap = {wdata, 8'h00};
    end
    if (rd)
    begin
      case (addr)
        `FDI_REG_CTRL: next_rdata = ctrl;
        `FDI_REG_TRACK: next_rdata = {1'b0, track};
        `FDI_REG_STATUS: next_rdata = status;
        `FDI_REG_STEPCFG: next_rdata = step_gap[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= `FDI_CTRL_RESET;
      step_gap <= `FDI_STEP_GAP_RESET;
      rdata <= 8'h00;
    end
    else
    begin
      ctrl <= next_ctrl;
      step_gap <= next_step_gap;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // seek sequencer
  // ****************************************
  fdi_seek_state_type state;
  fdi_seek_state_type next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic dir_in;
  logic next_dir_in;
  logic at_zero;

  assign at_zero = !sync_b.trk0_n;
  assign busy = (state != FDI_SEEK_IDLE);

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_dir_in = dir_in;
    next_track = track;
    case (state)
      FDI_SEEK_IDLE:
      begin
        // outward request at track zero is dropped
        if (step_req && (step_dir_in || !at_zero))
        begin
          next_dir_in = step_dir_in;
          next_count = 16'(`FDI_DIR_SETUP_CYC - 1);
          next_state = FDI_SEEK_SETUP;
        end
        if (at_zero)
        begin
          next_track = 7'h00;
        end
      end
      FDI_SEEK_SETUP:
      begin
        if (count == 16'h0000)
        begin
          next_count = 16'(`FDI_STEP_PULSE_CYC - 1);
          next_state = FDI_SEEK_PULSE;
        end
        else
        begin
          next_count = count - 16'h0001;
        end
      end
      FDI_SEEK_PULSE:
      begin
        if (count == 16'h0000)
        begin
          // one pulse is one track, except inward at the last track and outward at track zero, where the count holds
          if (dir_in)
          begin
            if (track != `FDI_LAST_TRACK)
            begin
              next_track = track + 7'h01;
            end
          end
          else if (track != 7'h00)
          begin
            next_track = track - 7'h01;
          end
          next_count = step_gap;
          next_state = FDI_SEEK_GAP;
        end
        else
        begin
          next_count = count - 16'h0001;
        end
      end
      FDI_SEEK_GAP:
      begin
        if (count == 16'h0000)
        begin
          next_state = FDI_SEEK_IDLE;
        end
        else
        begin
          next_count = count - 16'h0001;
        end
      end
      default:
      begin
        next_state = FDI_SEEK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= FDI_SEEK_IDLE;
      count <= 16'h0000;
      dir_in <= 1'b0;
      track <= 7'h00;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      dir_in <= next_dir_in;
      track <= next_track;
    end
  end

  // ****************************************
  // write path
  // ****************************************
  logic wpulse_n;

  fdi_write_pulser u_pulser (
    .clk(clk),
    .rst(rst),
    .gate(wgate),
    .flux(flux),
    .wpulse_n(wpulse_n)
  );

  // ****************************************
  // output pins
  // ****************************************
  fdi_drive_out_type next_out;

  always_comb
  begin
    next_out.sel0_n = !ctrl[`FDI_CTRL_SEL0];
    next_out.sel1_n = !ctrl[`FDI_CTRL_SEL1];
    next_out.sel23 = ctrl[`FDI_CTRL_OPT] && ctrl[`FDI_CTRL_SEL23];
    next_out.head1 = ctrl[`FDI_CTRL_OPT] && ctrl[`FDI_CTRL_HEAD1];
    next_out.hload_n = !ctrl[`FDI_CTRL_HLOAD];
    // held through setup, pulse and gap
    next_out.seek_in = dir_in;
    next_out.step_n = (state != FDI_SEEK_PULSE);
    next_out.wgate_n = !wgate;
    next_out.wpulse_n = wpulse_n;
    next_out.above43_n = !(wgate && track > `FDI_LAST_OUTER_TRACK);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drv_out <= '{sel0_n: 1'b1, sel1_n: 1'b1, sel23: 1'b0, head1: 1'b0,
        hload_n: 1'b1, seek_in: 1'b0, step_n: 1'b1, wgate_n: 1'b1,
        wpulse_n: 1'b1, above43_n: 1'b1};
    end
    else
    begin
      drv_out <= next_out;
    end
  end

endmodule : fdi_drive_if

// file: tb/fdi_drive_if_asserts.sv
`timescale 1ns/1ns
// ****
// pin and read data checks
// ****
module fdi_drive_if_asserts
  import fdi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // drive pins
  input wire fdi_drive_in_type drv_in,
  input wire fdi_drive_out_type drv_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_hload_level: assert property ($past(wr && addr == 4'h0, 2) |->
    drv_out.hload_n == !$past(wdata[4], 2)) else $error("hload");
  a_sel0_level: assert property ($past(wr && addr == 4'h0, 2) |->
    drv_out.sel0_n == !$past(wdata[0], 2)) else $error("sel0");
  a_sel1_level: assert property ($past(wr && addr == 4'h0, 2) |->
    drv_out.sel1_n == !$past(wdata[1] && !wdata[0], 2)) else $error("sel1");
  a_step_width: assert property ($fell(drv_out.step_n) |->
    (!drv_out.step_n) [*8] ##1 (!drv_out.step_n) [*8] ##1 (!drv_out.step_n) [*4]
    ##1 drv_out.step_n) else $error("step");
  a_dir_stable: assert property (!drv_out.step_n |->
    $stable(drv_out.seek_in)) else $error("dir");
  a_flux_width: assert property ($fell(drv_out.wpulse_n) |->
    (!drv_out.wpulse_n) [*5] ##1 drv_out.wpulse_n) else $error("flux");
  a_read_current: assert property (drv_out.wgate_n |->
    drv_out.above43_n) else $error("current");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata");
  a_wgate_ready: assert property (!drv_out.wgate_n |->
    !$past(drv_in.wperm_n, 3) && (!$past(drv_in.ready0_n, 3) || !$past(drv_in.ready1_n, 3)))
    else $error("wgate");
endmodule : fdi_drive_if_asserts

bind fdi_drive_if fdi_drive_if_asserts chk_u (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drv_in(drv_in), .drv_out(drv_out));

// file: tb/fdi_drive_model.sv
`timescale 1ns/1ns
// ****
// drive unit
// ****
module fdi_drive_model
  import fdi_pkg::*;
#(
  parameter int REV_CYC = 500
)
(
  // clock
  input wire logic clk,
  // controller side
  input wire fdi_drive_out_type drv_out,
  input wire logic [1:0] rdy,
  input wire logic wprot,
  // drive status
  output fdi_drive_in_type drv_in,
  output int pos
);
  int rev = 0;
  initial pos = 0;
  always @(negedge drv_out.step_n)
  begin
    if (drv_out.seek_in && pos < 76)
      pos <= pos + 1;
    else if (!drv_out.seek_in && pos > 0)
      pos <= pos - 1;
  end
  always @(posedge clk)
    rev <= (rev == REV_CYC - 1) ? 0 : rev + 1;
  always_comb
  begin
    drv_in.trk0_n = (pos != 0);
    drv_in.ready0_n = !rdy[0];
    drv_in.ready1_n = !rdy[1];
    drv_in.wperm_n = wprot;
    drv_in.index_n = (rev > 3);
    drv_in.raw_data = rev[1];
  end
endmodule : fdi_drive_model

// file: tb/floppy_drive_interface_signals_tb_top.sv
`timescale 1ns/1ns
// ****
// bench
// ****
module floppy_drive_interface_signals_tb_top;
  import fdi_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv, d;
  logic wr, rd, wprot, wg;
  logic [1:0] rdy;
  fdi_drive_in_type drv_in;
  fdi_drive_out_type drv_out;
  int pos, trk = 0, steps = 0, moves = 0, cyc = 0, bad_count = 0, num_checks = 0;
  initial forever #25 clk = ~clk;
  fdi_drive_if dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .drv_in(drv_in), .drv_out(drv_out));
  fdi_drive_model #(.REV_CYC(500)) drv_u (.clk(clk), .drv_out(drv_out), .rdy(rdy),
    .wprot(wprot), .drv_in(drv_in), .pos(pos));
  always @(negedge drv_out.step_n) steps++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      test_done();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task step(input logic dir, input int n);
    repeat (n)
    begin
      wreg(4'h1, {6'h00, dir, 1'b1});
      if (dir ? trk < 76 : trk > 0)
      begin
        trk += dir ? 1 : -1;
        moves++;
      end
      rv = 8'h40;
      for (int i = 0; i < 200 && rv[6]; i++) rreg(4'h3, rv);
      chk({7'h00, rv[6]}, 8'h00);
      chk({7'h00, drv_out.seek_in}, {7'h00, dir});
    end
  endtask : step
  task test_done;
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rdy = 2'b11;
    wprot = 1'b0;
    void'($urandom(59082));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wreg(4'h4, 8'h01);
    rreg(4'h4, rv);
    chk(rv, 8'h01);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk);
      d = 8'($urandom);
      rdy <= 2'($urandom);
      wprot <= 1'($urandom);
      wreg(4'h0, d);
      repeat (6) @(posedge clk);
      wg = d[5] && !wprot && (d[0] ? rdy[0] : d[1] && rdy[1]);
      chk({drv_out.sel0_n, drv_out.sel1_n, drv_out.sel23, drv_out.head1, drv_out.hload_n,
        drv_out.wgate_n, 2'b00}, {!d[0], !(d[1] && !d[0]), d[2] && d[6], d[3] && d[6],
        !d[4], !wg, 2'b00});
      rreg(4'h3, rv);
      chk(rv & 8'h8f, {wg, 3'b000, !wprot, rdy[1], rdy[0], 1'b1});
      rreg(4'h0, rv);
      chk(rv, {d[7:2], d[1] && !d[0], d[0]});
    end
    @(posedge clk);
    rdy <= 2'b01;
    wprot <= 1'b0;
    wreg(4'h0, 8'h31);
    step(1'b1, 45);
    repeat (4) @(posedge clk);
    chk({drv_out.wgate_n, drv_out.above43_n}, 8'h00);
    rreg(4'h1, rv);
    chk(rv, trk[7:0]);
    wreg(4'h2, 8'h01);
    @(posedge clk);
    #1 chk({7'h00, drv_out.wpulse_n}, 8'h00);
    step(1'b0, 1);
    repeat (4) @(posedge clk);
    chk({7'h00, drv_out.above43_n}, 8'h00);
    step(1'b0, 1);
    repeat (4) @(posedge clk);
    chk({7'h00, drv_out.above43_n}, 8'h01);
    step(1'b0, 44);
    chk(pos[7:0], trk[7:0]);
    rreg(4'h1, rv);
    chk(rv, trk[7:0]);
    chk(steps[7:0], moves[7:0]);
    rreg(4'h7, rv);
    chk(rv, 8'h00);
    rreg(4'h2, rv);
    chk(rv, 8'h00);
    test_done();
  end
endmodule : floppy_drive_interface_signals_tb_top
